// *** rtl/act_defs.svh ***
`ifndef ACT_DEFS_SVH
`define ACT_DEFS_SVH

// data widths
`define ACT_RNG_W     12
`define ACT_AZ_W      11
`define ACT_IDX_W     3
`define ACT_NH_W      4
`define ACT_NM_W      2
// table sizes: tracks and pending hits per azimuth element
`define ACT_NTRK      8
`define ACT_NHIT      8
`define ACT_LAST_IDX  3'h7
// medium-rate search limits
`define ACT_GATE      12'h001
`define ACT_MISS_LIM  2'h3
`define ACT_HIT_LIM   4'ha
`define ACT_DRIFT_LIM 12'h005
// counter start values of a new track
`define ACT_NH_INIT   4'h1
`define ACT_NM_INIT   2'h0

`endif

// *** rtl/act_pkg.sv ***
`include "act_defs.svh"

package act_pkg;

  typedef logic [`ACT_RNG_W-1:0] act_rng_t;
  typedef logic [`ACT_AZ_W-1:0]  act_az_t;
  typedef logic [`ACT_IDX_W-1:0] act_idx_t;
  typedef logic [`ACT_NH_W-1:0]  act_nh_t;
  typedef logic [`ACT_NM_W-1:0]  act_nm_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CORR = 4'b0010,
    ST_INIT = 4'b0100,
    ST_TERM = 4'b1000
  } act_state_t;

endpackage

// *** rtl/act_azimuth_centroid_tracker.sv ***
// Functional notes
// - inhibit set: output tagged azimuth and range
// - inhibit clear: run full track procedure
// - tag every hit with current azimuth
// - average repeated hits within gate of cell
// - track keeps ranges, azimuths, hit, miss counts
// - candidates lie within current range plus or minus gate
// - exact range wins, else nearest candidate
// - correlation updates range, azimuth, clears misses
// - correlated hit leaves pending list
// - uncorrelated track increments miss counter
// - hit counter increments every element
// - leftover hits start new tracks
// - new track: ranges, azimuth, counts 1/0
// - terminate on miss, hit or drift limit
// - output rounded means of ranges and azimuths
// - gate 1, misses 3, hits 10, drift 5
`timescale 1ns/1ps
`include "act_defs.svh"

module act_azimuth_centroid_tracker
  import act_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     arst_n_i,
  input  wire logic     hit_valid_i,
  input  wire act_rng_t hit_range_i,
  input  wire act_az_t  azimuth_i,
  input  wire logic     skip_centroid_flag_i,
  input  wire logic     elem_end_i,
  output logic          busy_o,
  output logic          out_valid_o,
  output act_rng_t      out_range_o,
  output act_az_t       out_azimuth_o,
  output act_nh_t       out_hits_o
);

  // track table
  logic     tv_r  [`ACT_NTRK];
  act_rng_t ro_r  [`ACT_NTRK];
  act_rng_t rc_r  [`ACT_NTRK];
  act_az_t  azo_r [`ACT_NTRK];
  act_az_t  azc_r [`ACT_NTRK];
  act_nh_t  nh_r  [`ACT_NTRK];
  act_nm_t  nm_r  [`ACT_NTRK];
  logic     tv_nxt  [`ACT_NTRK];
  act_rng_t ro_nxt  [`ACT_NTRK];
  act_rng_t rc_nxt  [`ACT_NTRK];
  act_az_t  azo_nxt [`ACT_NTRK];
  act_az_t  azc_nxt [`ACT_NTRK];
  act_nh_t  nh_nxt  [`ACT_NTRK];
  act_nm_t  nm_nxt  [`ACT_NTRK];
  // pending hit list, each hit with its tagged azimuth
  logic     hp_r  [`ACT_NHIT];
  act_rng_t hr_r  [`ACT_NHIT];
  act_az_t  hz_r  [`ACT_NHIT];
  logic     hp_nxt  [`ACT_NHIT];
  act_rng_t hr_nxt  [`ACT_NHIT];
  act_az_t  hz_nxt  [`ACT_NHIT];
  // sequencing and output
  act_state_t st_r, st_nxt;
  act_idx_t   idx_r, idx_nxt;
  logic [`ACT_IDX_W:0] hcnt_r, hcnt_nxt;
  logic       ov_r, ov_nxt;
  act_rng_t   orng_r, orng_nxt;
  act_az_t    oaz_r, oaz_nxt;
  act_nh_t    ohit_r, ohit_nxt;

  // gate search for the track at idx_r
  act_rng_t cur_rc;
  act_rng_t hdist [`ACT_NHIT];
  logic     hcand [`ACT_NHIT];
  logic     best_found;
  act_idx_t best_idx;
  act_rng_t best_dist;
  act_rng_t best_rng;
  logic     exact_any;
  act_nh_t  cur_nh;
  act_nm_t  cur_nm;

  assign cur_rc = rc_r[idx_r];
  assign cur_nh = nh_r[idx_r];
  assign cur_nm = nm_r[idx_r];
  // distance of each pending hit to the track's current range
  for (genvar j = 0; j < `ACT_NHIT; j++) begin : g_dist
    assign hdist[j] = (hr_r[j] > cur_rc) ? hr_r[j] - cur_rc
                                         : cur_rc - hr_r[j];
    assign hcand[j] = hp_r[j] && (hdist[j] <= `ACT_GATE);
  end

  // nearest candidate; distance 0 always beats any other
  always_comb begin
    best_found = 1'b0;
    best_idx   = '0;
    best_dist  = '0;
    best_rng   = '0;
    exact_any  = 1'b0;
    for (int j = 0; j < `ACT_NHIT; j++) begin
      if (hcand[j] && hdist[j] == '0) begin
        exact_any = 1'b1;
      end
      if (hcand[j] && (!best_found || hdist[j] < best_dist ||
          (hdist[j] == best_dist && hr_r[j] < best_rng))) begin
        best_found = 1'b1;
        best_idx   = act_idx_t'(j);
        best_dist  = hdist[j];
        best_rng   = hr_r[j];
      end
    end
  end

  // lowest free track slot for initiation
  logic     free_found;
  act_idx_t free_idx;
  always_comb begin
    free_found = 1'b0;
    free_idx   = '0;
    for (int t = `ACT_NTRK - 1; t >= 0; t--) begin
      if (!tv_r[t]) begin
        free_found = 1'b1;
        free_idx   = act_idx_t'(t);
      end
    end
  end

  // termination test and rounded means for the track at idx_r
  act_rng_t drift;
  logic     term_hit;
  logic [`ACT_RNG_W:0] rsum;
  logic [`ACT_AZ_W:0]  asum;
  act_rng_t mean_rng;
  act_az_t  mean_az;
  assign drift = (ro_r[idx_r] > cur_rc) ? ro_r[idx_r] - cur_rc
                                        : cur_rc - ro_r[idx_r];
  assign term_hit = tv_r[idx_r] && (cur_nm == `ACT_MISS_LIM ||
                    cur_nh == `ACT_HIT_LIM ||
                    drift > `ACT_DRIFT_LIM);
  // adding one before the halving rounds the mean half up
  assign rsum = {1'b0, ro_r[idx_r]} + {1'b0, cur_rc} + 13'h001;
  assign asum = {1'b0, azo_r[idx_r]} + {1'b0, azc_r[idx_r]} + 12'h001;
  assign mean_rng = rsum[`ACT_RNG_W:1];
  assign mean_az  = asum[`ACT_AZ_W:1];

  // next state; tracks are visited in fixed index order one per cycle,
  // so a hit claimed by a lower track is gone for the higher ones
  always_comb begin
    tv_nxt   = tv_r;
    ro_nxt   = ro_r;
    rc_nxt   = rc_r;
    azo_nxt  = azo_r;
    azc_nxt  = azc_r;
    nh_nxt   = nh_r;
    nm_nxt   = nm_r;
    hp_nxt   = hp_r;
    hr_nxt   = hr_r;
    hz_nxt   = hz_r;
    st_nxt   = st_r;
    idx_nxt  = idx_r;
    hcnt_nxt = hcnt_r;
    ov_nxt   = 1'b0;
    orng_nxt = orng_r;
    oaz_nxt  = oaz_r;
    ohit_nxt = ohit_r;
    unique case (st_r)
      ST_IDLE: begin
        if (hit_valid_i && skip_centroid_flag_i) begin
          ov_nxt   = 1'b1;
          orng_nxt = hit_range_i;
          oaz_nxt  = azimuth_i;
          ohit_nxt = '0;
        end else if (hit_valid_i && hcnt_r < `ACT_NHIT) begin
          // hits beyond the list size are dropped for this element
          hp_nxt[hcnt_r[`ACT_IDX_W-1:0]] = 1'b1;
          hr_nxt[hcnt_r[`ACT_IDX_W-1:0]] = hit_range_i;
          hz_nxt[hcnt_r[`ACT_IDX_W-1:0]] = azimuth_i;
          hcnt_nxt = hcnt_r + 4'h1;
        end
        if (elem_end_i && !skip_centroid_flag_i) begin
          st_nxt  = ST_CORR;
          idx_nxt = '0;
        end
      end
      ST_CORR: begin
        if (tv_r[idx_r]) begin
          nh_nxt[idx_r] = cur_nh + 4'h1;
          if (best_found) begin
            rc_nxt[idx_r]    = best_rng;
            azc_nxt[idx_r]   = hz_r[best_idx];
            nm_nxt[idx_r]    = '0;
            hp_nxt[best_idx] = 1'b0;
          end else begin
            nm_nxt[idx_r] = cur_nm + 2'h1;
          end
        end
        idx_nxt = idx_r + 3'h1;
        if (idx_r == `ACT_LAST_IDX) begin
          st_nxt = ST_INIT;
        end
      end
      ST_INIT: begin
        if (hp_r[idx_r] && free_found) begin
          tv_nxt[free_idx]  = 1'b1;
          ro_nxt[free_idx]  = hr_r[idx_r];
          rc_nxt[free_idx]  = hr_r[idx_r];
          azo_nxt[free_idx] = hz_r[idx_r];
          azc_nxt[free_idx] = hz_r[idx_r];
          nh_nxt[free_idx]  = `ACT_NH_INIT;
          nm_nxt[free_idx]  = `ACT_NM_INIT;
        end
        hp_nxt[idx_r] = 1'b0;
        idx_nxt = idx_r + 3'h1;
        if (idx_r == `ACT_LAST_IDX) begin
          st_nxt = ST_TERM;
        end
      end
      ST_TERM: begin
        if (term_hit) begin
          tv_nxt[idx_r] = 1'b0;
          ov_nxt   = 1'b1;
          orng_nxt = mean_rng;
          oaz_nxt  = mean_az;
          ohit_nxt = cur_nh;
        end
        idx_nxt = idx_r + 3'h1;
        if (idx_r == `ACT_LAST_IDX) begin
          st_nxt   = ST_IDLE;
          hcnt_nxt = '0;
        end
      end
    endcase
  end

  // register everything; reset clears every table entry, not only the valid bits
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int t = 0; t < `ACT_NTRK; t++) begin
        tv_r[t]  <= 1'b0;
        ro_r[t]  <= '0;
        rc_r[t]  <= '0;
        azo_r[t] <= '0;
        azc_r[t] <= '0;
        nh_r[t]  <= '0;
        nm_r[t]  <= '0;
      end
      for (int j = 0; j < `ACT_NHIT; j++) begin
        hp_r[j] <= 1'b0;
        hr_r[j] <= '0;
        hz_r[j] <= '0;
      end
      st_r   <= ST_IDLE;
      idx_r  <= '0;
      hcnt_r <= '0;
      ov_r   <= 1'b0;
      orng_r <= '0;
      oaz_r  <= '0;
      ohit_r <= '0;
    end else begin
      tv_r   <= tv_nxt;
      ro_r   <= ro_nxt;
      rc_r   <= rc_nxt;
      azo_r  <= azo_nxt;
      azc_r  <= azc_nxt;
      nh_r   <= nh_nxt;
      nm_r   <= nm_nxt;
      hp_r   <= hp_nxt;
      hr_r   <= hr_nxt;
      hz_r   <= hz_nxt;
      st_r   <= st_nxt;
      idx_r  <= idx_nxt;
      hcnt_r <= hcnt_nxt;
      ov_r   <= ov_nxt;
      orng_r <= orng_nxt;
      oaz_r  <= oaz_nxt;
      ohit_r <= ohit_nxt;
    end
  end

  assign busy_o        = (st_r != ST_IDLE);
  assign out_valid_o   = ov_r;
  assign out_range_o   = orng_r;
  assign out_azimuth_o = oaz_r;
  assign out_hits_o    = ohit_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence corr_phase_s;
    (st_r == ST_CORR) [*8];
  endsequence
  sequence init_phase_s;
    (st_r == ST_INIT) [*8];
  endsequence
  sequence term_phase_s;
    (st_r == ST_TERM) [*8];
  endsequence
  inhibit_pass_a: assert property (
    (st_r == ST_IDLE && hit_valid_i && skip_centroid_flag_i) |=>
    (out_valid_o && out_range_o == $past(hit_range_i) &&
     out_azimuth_o == $past(azimuth_i)))
    else $error("inhibited hit not passed through");
  full_sequence_a: assert property (
    (st_r == ST_IDLE && elem_end_i && !skip_centroid_flag_i) |=>
    corr_phase_s ##1 init_phase_s ##1 term_phase_s ##1 (st_r == ST_IDLE))
    else $error("track procedure sequence broken");
  corr_update_a: assert property (
    (st_r == ST_CORR && tv_r[idx_r] && best_found) |=>
    (rc_r[$past(idx_r)] == $past(best_rng) && nm_r[$past(idx_r)] == '0))
    else $error("correlated track not updated");
  miss_count_a: assert property (
    (st_r == ST_CORR && tv_r[idx_r] && !best_found) |=>
    (nm_r[$past(idx_r)] == act_nm_t'($past(cur_nm) + 2'h1)))
    else $error("miss counter not incremented");
  hit_count_a: assert property (
    (st_r == ST_CORR && tv_r[idx_r]) |=>
    (nh_r[$past(idx_r)] == act_nh_t'($past(cur_nh) + 4'h1)))
    else $error("hit counter not incremented");
  claim_clear_a: assert property (
    (st_r == ST_CORR && tv_r[idx_r] && best_found) |=>
    !hp_r[$past(best_idx)])
    else $error("claimed hit still pending");
  gate_limit_a: assert property (
    (st_r == ST_CORR && best_found) |-> (best_dist <= 12'h001))
    else $error("hit outside gate correlated");
  exact_wins_a: assert property (
    (st_r == ST_CORR && exact_any) |-> (best_dist == '0))
    else $error("exact range hit not chosen");
  new_track_a: assert property (
    (st_r == ST_INIT && hp_r[idx_r] && free_found) |=>
    (tv_r[$past(free_idx)] && nh_r[$past(free_idx)] == 4'h1 &&
     nm_r[$past(free_idx)] == 2'h0 &&
     ro_r[$past(free_idx)] == rc_r[$past(free_idx)]))
    else $error("new track badly initialised");
  term_output_a: assert property (
    (st_r == ST_TERM && term_hit) |=>
    (out_valid_o && out_range_o == $past(mean_rng) &&
     out_azimuth_o == $past(mean_az) && !tv_r[$past(idx_r)]))
    else $error("terminated track not reported");
endmodule // act_azimuth_centroid_tracker

// *** verif/act_hit_source.sv ***
`timescale 1ns/1ps

module act_hit_source
  import act_pkg::*;
(
  input  wire logic clk_i,
  output logic      hit_valid_o,
  output act_rng_t  hit_range_o,
  output act_az_t   azimuth_o,
  output logic      flag_o,
  output logic      elem_end_o
);
  // idle lines at time zero
  initial begin
    hit_valid_o = 1'b0;
    hit_range_o = 12'h000;
    azimuth_o   = 11'h000;
    flag_o      = 1'b0;
    elem_end_o  = 1'b0;
  end

  // one hit, held up to the taking edge; released lines show the inverse
  task automatic send(input act_rng_t r, input act_az_t a, input logic f);
    @(posedge clk_i);
    #1;
    hit_valid_o = 1'b1;
    hit_range_o = r;
    azimuth_o   = a;
    flag_o      = f;
    @(posedge clk_i);
    #1;
    hit_valid_o = 1'b0;
    hit_range_o = ~r;
    azimuth_o   = ~a;
  endtask

  // end of element; with the flag set the block must stay idle
  task automatic finish_elem(input logic f);
    @(posedge clk_i);
    #1;
    elem_end_o = 1'b1;
    flag_o     = f;
    @(posedge clk_i);
    #1;
    elem_end_o = 1'b0;
  endtask
endmodule // act_hit_source

// *** verif/tb_top.sv ***
`timescale 1ns/1ps

module tb_top import act_pkg::*; ;
  logic     clk_i;
  logic     arst_n_i;
  logic     hv;
  act_rng_t hr;
  act_az_t  ha;
  logic     fl;
  logic     ee;
  logic     busy;
  logic     ov;
  act_rng_t orng;
  act_az_t  oaz;
  act_nh_t  ohit;
  act_rng_t q_r[$];
  act_az_t  q_a[$];
  act_nh_t  q_h[$];
  int       errors = 0;
  int       n_compared = 0;

  act_hit_source i_act_hit_source (.clk_i(clk_i), .hit_valid_o(hv),
    .hit_range_o(hr), .azimuth_o(ha), .flag_o(fl), .elem_end_o(ee));

  act_azimuth_centroid_tracker i_act_azimuth_centroid_tracker (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .hit_valid_i(hv),
    .hit_range_i(hr), .azimuth_i(ha), .skip_centroid_flag_i(fl),
    .elem_end_i(ee), .busy_o(busy), .out_valid_o(ov),
    .out_range_o(orng), .out_azimuth_o(oaz), .out_hits_o(ohit));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // collect every output pulse mid-cycle, well away from its launching edge
  always @(negedge clk_i) begin
    if (ov === 1'b1) begin
      q_r.push_back(orng);
      q_a.push_back(oaz);
      q_h.push_back(ohit);
    end
  end

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // check one collected output against its rounded means and count
  task automatic chk_out(input int i, input act_rng_t r, input act_az_t a,
                         input act_nh_t h);
    chk("range", r, q_r[i]);
    chk("azimuth", 12'(a), 12'(q_a[i]));
    chk("hits", 12'(h), 12'(q_h[i]));
  endtask

  // one element of up to three hits, then the busy window is timed
  task automatic run_elem(input int n, input act_rng_t r0, r1, r2,
                          input act_az_t a, input int nexp);
    int       k;
    act_rng_t rs[3];
    rs = '{r0, r1, r2};
    q_r.delete();
    q_a.delete();
    q_h.delete();
    for (k = 0; k < n; k++)
      i_act_hit_source.send(rs[k], a, 1'b0);
    i_act_hit_source.finish_elem(1'b0);
    k = 0;
    while (busy !== 1'b1 && k < 4) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    k = 0;
    while (busy === 1'b1 && k < 40) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (k >= 40) begin
      errors++;
      tally_and_finish();
    end
    chk("busy cycles", 12'h018, 12'(k));
    @(posedge clk_i);
    #1;
    chk("outputs", 12'(nexp), 12'(q_r.size()));
  endtask

  // inhibit set: tagged azimuth and range come straight out
  task automatic t_pass();
    i_act_hit_source.send(12'h123, 11'h045, 1'b1);
    chk("pass valid", 12'h001, 12'(ov));
    chk("pass range", 12'h123, orng);
    chk("pass azimuth", 12'h045, 12'(oaz));
    chk("pass hits", 12'h000, 12'(ohit));
    // element end while inhibited must not start the track pass
    i_act_hit_source.finish_elem(1'b1);
    chk("inhibit busy", 12'h000, 12'(busy));
    chk("pass pulse end", 12'h000, 12'(ov));
  endtask

  // tie picks lower bin, out-of-gate and leftover hits open tracks
  task automatic t_miss_tie();
    run_elem(1, 12'h064, 12'h000, 12'h000, 11'h00a, 0);
    run_elem(3, 12'h065, 12'h063, 12'h066, 11'h00c, 0);
    run_elem(0, 12'h000, 12'h000, 12'h000, 11'h00d, 0);
    run_elem(0, 12'h000, 12'h000, 12'h000, 11'h00e, 0);
    run_elem(0, 12'h000, 12'h000, 12'h000, 11'h00f, 3);
    chk_out(0, 12'h064, 11'h00b, 4'h5);
    chk_out(1, 12'h065, 11'h00c, 4'h4);
    chk_out(2, 12'h066, 11'h00c, 4'h4);
  endtask

  // steady target stops on the hit limit of ten elements
  task automatic t_hit_lim();
    int k;
    for (k = 1; k <= 10; k++)
      run_elem(1, 12'h0c8, 12'h000, 12'h000, 11'(3 * k), k / 10);
    chk_out(0, 12'h0c8, 11'h011, 4'ha);
  endtask

  // target walking one bin per element stops once drift passes five
  task automatic t_drift();
    int k;
    for (k = 0; k <= 6; k++)
      run_elem(1, 12'(300 + k), 12'h000, 12'h000, 11'(5 + k), k / 6);
    chk_out(0, 12'h12f, 11'h008, 4'h7);
  endtask

  initial begin
    arst_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    chk("reset busy", 12'h000, 12'(busy));
    chk("reset valid", 12'h000, 12'(ov));
    #1;
    arst_n_i = 1'b1;
    t_pass();
    t_miss_tie();
    t_hit_lim();
    t_drift();
    tally_and_finish();
  end
endmodule // tb_top
